// ---- src/nv_resistor_map.vh ----
// Purpose: Offsets, field positions, reset values and timing for the
//          nonvolatile resistor setting registers.
// Assumes: Clock of 40 MHz.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef NV_RESISTOR_MAP_VH
`define NV_RESISTOR_MAP_VH
`define RESISTOR0_POSITION_ADDR  8'hf8
`define RESISTOR1_POSITION_ADDR  8'hf9
`define RESISTOR2_POSITION_ADDR  8'hfa
`define POSITION_RESET           8'h7f
`define POSITION_MAX             8'h7f
`define WIPER_RESET              7'h7f
`define HIZ_BIT                  7
`define DEV_PATTERN3             4'ha
`define DEV_PATTERN1             6'h28
`define CLOCK_KHZ                40000
`define NV_WRITE_US              10000
`define STARTUP_US               2000
`define NV_WRITE_CYCLES          ((`NV_WRITE_US * `CLOCK_KHZ) / 1000)
`define STARTUP_CYCLES           ((`STARTUP_US * `CLOCK_KHZ) / 1000)
`endif

// ---- src/nv_setting_store.v ----
// Purpose: Nonvolatile store for the three resistor settings, with the
//          startup load delay and the timed internal write.
// Assumes: One write request at a time; requests while busy are dropped.
// Notes:   Flip-flops stand in for the EEPROM cells.
`default_nettype none
`include "nv_resistor_map.vh"
module nv_setting_store #(
  parameter NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter STARTUP_CYCLES  = `STARTUP_CYCLES
) (
  input  wire        clock,     // System clock.
  input  wire        rstn,      // Synchronous reset, active low.
  input  wire        wr_req,    // One-cycle write request.
  input  wire [1:0]  wr_idx,    // Resistor index to write.
  input  wire [7:0]  wr_data,   // Byte to store.
  output reg         busy_r,    // Startup load or write in progress.
  output wire [23:0] cells      // Stored bytes, resistor 2 in the top byte.
);
  reg [7:0]  mem_r [0:2];
  reg [1:0]  idx_r;
  reg [7:0]  data_r;
  reg        writing_r;
  reg [31:0] count_r;
  integer    i;

  assign cells = {mem_r[2], mem_r[1], mem_r[0]};

  always @(posedge clock) begin
    if (!rstn) begin
      for (i = 0; i < 3; i = i + 1) begin
        mem_r[i] <= `POSITION_RESET;                       // [RULE2]
      end
      busy_r    <= 1'b1;                                   // [RULE14]
      writing_r <= 1'b0;
      idx_r     <= 2'h0;
      data_r    <= 8'h00;
      count_r   <= STARTUP_CYCLES;
    end else if (busy_r) begin
      if (count_r <= 32'h1) begin
        busy_r    <= 1'b0;
        writing_r <= 1'b0;
        if (writing_r) begin
          mem_r[idx_r] <= data_r;                          // [RULE2]
        end
      end else begin
        count_r <= count_r - 32'h1;
      end
    end else if (wr_req && wr_idx < 2'h3) begin
      busy_r    <= 1'b1;
      writing_r <= 1'b1;
      idx_r     <= wr_idx;
      data_r    <= wr_data;
      count_r   <= NV_WRITE_CYCLES;
    end
  end
endmodule // nv_setting_store
`default_nettype wire

// ---- src/nv_resistor_setting_regs.v ----
// Purpose: Two-wire bus slave holding three nonvolatile resistor settings.
// Assumes: Bus lines sampled by the 40 MHz clock; bus up to 400 kHz.
// Notes:   Settings reach the outputs once the internal write finishes.
//
// Overview of operation
// RULE1: Three byte registers at F8h, F9h, FAh select resistors 0, 1, 2.
// RULE2: Settings reset to 7Fh and are kept in nonvolatile storage.
// RULE3: Codes 00h to 7Fh give 128 positions, minimum to maximum.
// RULE4: A value above 7Fh sets the top bit, making the resistor high-Z.
// RULE5: Master writes 00h for low and 80h for high-Z switch use.
// RULE6: The nonvolatile write starts only after the closing stop.
// RULE7: Address select bits are compared with hard-wired select pins.
// RULE8: Bus clock up to 100 kHz standard or 400 kHz fast.
// RULE9: Clock is input only; data is pulled low, never driven high.
// RULE10: Address is 1010 plus three select bits, or 101000 plus one.
// RULE11: Write is address, register byte, data byte, each acked, then stop.
// RULE12: Read sets pointer, repeated start, one byte, no-ack, stop.
// RULE13: No address acknowledge while the internal write runs.
// RULE14: Settings load before bus answers; reads return the full byte.
`default_nettype none
`include "nv_resistor_map.vh"
module nv_resistor_setting_regs #(
  parameter SELECT_PINS     = 3,
  parameter NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter STARTUP_CYCLES  = `STARTUP_CYCLES
) (
  input  wire       clock,                       // System clock, 40 MHz.
  input  wire       rstn,                        // Sync reset, active low.
  input  wire       scl_in,                      // Bus clock pin.
  input  wire       sda_in,                      // Bus data pin level.
  output reg        sda_out,                     // Data drive value, 0.
  output reg        sda_oe,                      // High pulls data low.
  input  wire       address_select_bit0,         // Select pin 0.
  input  wire       address_select_bit1,         // Select pin 1.
  input  wire       address_select_bit2,         // Select pin 2.
  output reg  [6:0] resistor0_wiper,             // Resistor 0 position.
  output reg  [6:0] resistor1_wiper,             // Resistor 1 position.
  output reg  [6:0] resistor2_wiper,             // Resistor 2 position.
  output reg  [2:0] high_impedance_control_bit,  // High-Z per resistor.
  output reg        nv_busy                      // Load or write running.
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV  = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_REG  = 3'h3;
  localparam ST_DAT  = 3'h4;
  localparam ST_RD   = 3'h5;
  localparam ST_MACK = 3'h6;
  localparam ST_WAIT = 3'h7;

  // ********************************************************************
  // Pin synchronisers and bus conditions.
  // ********************************************************************
  reg  [1:0] scl_sync_r;
  reg  [1:0] sda_sync_r;
  reg  [2:0] sel_sync0_r;
  reg  [2:0] sel_sync1_r;
  reg        scl_d_r;
  reg        sda_d_r;

  always @(posedge clock) begin
    if (!rstn) begin
      scl_sync_r  <= 2'h3;
      sda_sync_r  <= 2'h3;
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      sel_sync0_r <= 3'h0;
      sel_sync1_r <= 3'h0;
    end else begin
      scl_sync_r  <= {scl_sync_r[0], scl_in};              // [RULE9]
      sda_sync_r  <= {sda_sync_r[0], sda_in};              // [RULE8]
      scl_d_r     <= scl_sync_r[1];
      sda_d_r     <= sda_sync_r[1];
      sel_sync0_r <= {address_select_bit2, address_select_bit1,
                      address_select_bit0};
      sel_sync1_r <= sel_sync0_r;
    end
  end

  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ********************************************************************
  // Address match and register decode.
  // ********************************************************************
  function dev_match;
    input [6:0] dev;
    input [2:0] sel;
    begin
      if (SELECT_PINS == 1) begin
        dev_match = (dev == {`DEV_PATTERN1, sel[0]});      // [RULE10]
      end else begin
        dev_match = (dev == {`DEV_PATTERN3, sel});         // [RULE7]
      end
    end
  endfunction

  function [1:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)                                          // [RULE1]
        `RESISTOR0_POSITION_ADDR: reg_index = 2'h0;
        `RESISTOR1_POSITION_ADDR: reg_index = 2'h1;
        `RESISTOR2_POSITION_ADDR: reg_index = 2'h2;
        default:                  reg_index = 2'h3;
      endcase
    end
  endfunction

  // ********************************************************************
  // Nonvolatile store.
  // ********************************************************************
  wire        store_busy;
  wire [23:0] cells;
  reg         wr_req_r;
  reg  [1:0]  wr_idx_r;
  reg  [7:0]  wr_data_r;

  nv_setting_store #(
    .NV_WRITE_CYCLES (NV_WRITE_CYCLES),
    .STARTUP_CYCLES  (STARTUP_CYCLES)
  ) u_store (
    .clock   (clock),
    .rstn    (rstn),
    .wr_req  (wr_req_r),
    .wr_idx  (wr_idx_r),
    .wr_data (wr_data_r),
    .busy_r  (store_busy),
    .cells   (cells)
  );

  // Outputs follow the stored bytes whenever the store is idle.
  always @(posedge clock) begin
    if (!rstn) begin
      resistor0_wiper            <= `WIPER_RESET;
      resistor1_wiper            <= `WIPER_RESET;
      resistor2_wiper            <= `WIPER_RESET;
      high_impedance_control_bit <= 3'h0;
      nv_busy                    <= 1'b1;
    end else begin
      nv_busy <= store_busy;
      if (!store_busy) begin
        resistor0_wiper <= cells[6:0];                     // [RULE3]
        resistor1_wiper <= cells[14:8];
        resistor2_wiper <= cells[22:16];
        high_impedance_control_bit <= {cells[16 + `HIZ_BIT],
                                       cells[8 + `HIZ_BIT],
                                       cells[`HIZ_BIT]};   // [RULE4]
      end
    end
  end

  // ********************************************************************
  // Bus slave state machine.
  // ********************************************************************
  reg [2:0] state_r;
  reg [2:0] next_r;
  reg [3:0] cnt_r;
  reg [7:0] shift_r;
  reg [7:0] ptr_r;
  reg [7:0] out_r;
  reg       pend_r;
  reg [7:0] rd_byte;

  always @* begin
    case (reg_index(ptr_r))
      2'h0:    rd_byte = cells[7:0];                       // [RULE14]
      2'h1:    rd_byte = cells[15:8];
      2'h2:    rd_byte = cells[23:16];
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (!rstn) begin
      state_r   <= ST_IDLE;
      next_r    <= ST_IDLE;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 8'h00;
      out_r     <= 8'h00;
      pend_r    <= 1'b0;
      wr_req_r  <= 1'b0;
      wr_idx_r  <= 2'h0;
      wr_data_r <= 8'h00;
      sda_out   <= 1'b0;                                   // [RULE9]
      sda_oe    <= 1'b0;
    end else begin
      wr_req_r <= 1'b0;
      if (stop_c) begin
        state_r <= ST_IDLE;
        sda_oe  <= 1'b0;
        pend_r  <= 1'b0;
        wr_req_r <= pend_r;                                // [RULE6]
      end else if (start_c) begin
        state_r <= ST_DEV;
        cnt_r   <= 4'h0;
        sda_oe  <= 1'b0;
        pend_r  <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_DEV, ST_REG, ST_DAT: begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r   <= cnt_r + 4'h1;
          end
          ST_RD: begin
            cnt_r <= cnt_r + 4'h1;
          end
          ST_MACK: begin
            state_r <= ST_WAIT;                            // [RULE12]
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_DEV: begin
            if (cnt_r == 4'h8) begin
              if (dev_match(shift_r[7:1], sel_sync1_r) && !store_busy) begin
                sda_oe  <= 1'b1;                           // [RULE13]
                state_r <= ST_ACK;
                next_r  <= shift_r[0] ? ST_RD : ST_REG;
              end else begin
                state_r <= ST_WAIT;
              end
            end
          end
          ST_REG: begin
            if (cnt_r == 4'h8) begin
              ptr_r   <= shift_r;
              sda_oe  <= 1'b1;
              state_r <= ST_ACK;
              next_r  <= ST_DAT;
            end
          end
          ST_DAT: begin
            if (cnt_r == 4'h8) begin
              if (reg_index(ptr_r) != 2'h3) begin
                pend_r    <= 1'b1;
                wr_idx_r  <= reg_index(ptr_r);
                wr_data_r <= shift_r;                      // [RULE4]
                sda_oe    <= 1'b1;
                state_r   <= ST_ACK;
                next_r    <= ST_WAIT;
              end else begin
                state_r <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            cnt_r   <= 4'h0;
            state_r <= next_r;
            if (next_r == ST_RD) begin
              sda_oe <= ~rd_byte[7];
              out_r  <= {rd_byte[6:0], 1'b0};
            end else begin
              sda_oe <= 1'b0;
            end
          end
          ST_RD: begin
            if (cnt_r == 4'h8) begin
              sda_oe  <= 1'b0;
              state_r <= ST_MACK;
            end else begin
              sda_oe <= ~out_r[7];                         // [RULE9]
              out_r  <= {out_r[6:0], 1'b0};
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // nv_resistor_setting_regs
`default_nettype wire

// ---- tb/nv_regs_asserts.sv ----
// Purpose: Port assertions for the resistor setting registers.
// Assumes: Short store counts handed on by the bind.
// Notes:   Bound to every instance of the block.
`default_nettype none
module nv_regs_asserts #(
  parameter NV_WRITE_CYCLES = 50,
  parameter STARTUP_CYCLES  = 20
) (
  input wire logic       clock,                      // Clock.
  input wire logic       rstn,                       // Reset.
  input wire logic       scl_in,                     // Bus clock.
  input wire logic       sda_in,                     // Bus data.
  input wire logic       sda_out,                    // Drive value.
  input wire logic       sda_oe,                     // Pull enable.
  input wire logic [6:0] resistor0_wiper,            // Position 0.
  input wire logic [6:0] resistor1_wiper,            // Position 1.
  input wire logic [6:0] resistor2_wiper,            // Position 2.
  input wire logic [2:0] high_impedance_control_bit, // High-Z bits.
  input wire logic       nv_busy                     // Store busy.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] busy_cnt_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  always @(posedge clock) begin
    if (!rstn || !nv_busy) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= busy_cnt_r + 32'h1;
  end
  drive_low_only_a: assert property (
    sda_out == 1'b0) else $error("data driven high");
  reset_values_a: assert property (
    $rose(rstn) |-> nv_busy && !sda_oe && high_impedance_control_bit == 3'h0
    && {resistor2_wiper, resistor1_wiper, resistor0_wiper} == {3{7'h7f}})
    else $error("bad value after reset");
  busy_no_ack_a: assert property (
    nv_busy |-> !sda_oe) else $error("ack while busy");
  outputs_hold_a: assert property (
    !$stable({resistor2_wiper, resistor1_wiper, resistor0_wiper,
    high_impedance_control_bit}) |-> nv_busy || $past(nv_busy))
    else $error("setting changed outside write");
  oe_scl_low_a: assert property (
    !$stable(sda_oe) |-> !scl_in) else $error("data moved in clock high");
  busy_after_stop_a: assert property (
    $rose(nv_busy) |-> scl_in && sda_in) else $error("write before stop");
  busy_length_a: assert property (
    $fell(nv_busy) |-> busy_cnt_r inside
    {[STARTUP_CYCLES-2:STARTUP_CYCLES+4], [NV_WRITE_CYCLES-2:NV_WRITE_CYCLES+4]})
    else $error("busy length wrong");
  oe_release_a: assert property (
    $rose(sda_oe) |-> ##[1:100] !sda_oe) else $error("data held low");
endmodule // nv_regs_asserts
bind nv_resistor_setting_regs nv_regs_asserts #(
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES)
) u_nv_regs_asserts (.clock, .rstn, .scl_in, .sda_in, .sda_out, .sda_oe,
  .resistor0_wiper, .resistor1_wiper, .resistor2_wiper,
  .high_impedance_control_bit, .nv_busy);
`default_nettype wire

// ---- tb/bus_master.sv ----
// Purpose: Two-wire bus master for the setting registers.
// Assumes: Data line has a pullup; tasks start on a falling clock edge.
// Notes:   Steps of 50 ns keep every change off the rising edge.
`default_nettype none
module bus_master (
  output logic     scl,     // Bus clock, master only.
  output logic     sda_low, // High pulls data low.
  input wire logic sda      // Resolved data line.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start;
    #50 sda_low = 1'b0;
    #50 scl = 1'b1;
    #50 sda_low = 1'b1;
    #50 scl = 1'b0;
  endtask
  task automatic stop;
    #50 sda_low = 1'b1;
    #50 scl = 1'b1;
    #50 sda_low = 1'b0;
    #100;
  endtask
  task automatic bit_slot(input logic b, output logic r);
    #50 sda_low = !b;
    #50 scl = 1'b1;
    #50 r = sda;
    #50 scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ack = !r;
  endtask
  task automatic read_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(1'b1, r);
  endtask
endmodule // bus_master
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the resistor setting registers.
// Assumes: Short store counts; bus clock of 200 ns period.
// Notes:   Ordinary writes come from a table; odd cases follow it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam NVW = 400;
  localparam STU = 100;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  sel = 3'h5;
  logic        one_pin = 1'b0;
  logic        sel1 = 1'b0;
  wire logic   scl, sda_low, sda_oe, sda, nv_busy;
  wire logic   sda_oe1, nv_busy1;
  wire logic [6:0] w0, w1, w2, v0, v1, v2;
  wire logic [2:0] hiz, hiz1;
  // Address and busy flag of whichever device the tasks talk to.
  wire logic [6:0] dev = one_pin ? {6'h28, sel1} : {4'ha, sel};
  wire logic   busy_sel = one_pin ? nv_busy1 : nv_busy;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [7:0]  exp_r [0:2] = '{8'h7f, 8'h7f, 8'h7f};
  logic [7:0]  rd;
  logic        ak, ak2;
  // Register offset, data byte, data ack expected.
  logic [16:0] rows [0:5] = '{{8'hf8, 8'h00, 1'b1}, {8'hf9, 8'h80, 1'b1},
    {8'hfa, 8'h7f, 1'b1}, {8'hf8, 8'hff, 1'b1}, {8'hf9, 8'h01, 1'b1},
    {8'hfb, 8'h55, 1'b0}};
  assign sda = ~(sda_low | sda_oe | sda_oe1);
  always #12.5 clock = ~clock;
  bus_master u_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda));
  nv_resistor_setting_regs #(
    .SELECT_PINS(3), .NV_WRITE_CYCLES(NVW), .STARTUP_CYCLES(STU)
  ) u_nv_resistor_setting_regs (
    .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .address_select_bit0(sel[0]),
    .address_select_bit1(sel[1]), .address_select_bit2(sel[2]),
    .resistor0_wiper(w0), .resistor1_wiper(w1), .resistor2_wiper(w2),
    .high_impedance_control_bit(hiz), .nv_busy(nv_busy));
  nv_resistor_setting_regs #(
    .SELECT_PINS(1), .NV_WRITE_CYCLES(NVW), .STARTUP_CYCLES(STU)
  ) u_nv_resistor_setting_regs1 (
    .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe1), .address_select_bit0(sel1),
    .address_select_bit1(1'b0), .address_select_bit2(1'b0),
    .resistor0_wiper(v0), .resistor1_wiper(v1), .resistor2_wiper(v2),
    .high_impedance_control_bit(hiz1), .nv_busy(nv_busy1));
  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_level(input logic v);
    int n;
    n = 0;
    while (busy_sel !== v && n < 1000) begin
      @(negedge clock);
      n++;
    end
    if (busy_sel !== v) begin
      chk(busy_sel, v);
      results();
    end
  endtask
  task automatic probe(input logic [7:0] dev, output logic ok);
    u_bus_master.start();
    u_bus_master.send_byte(dev, ok);
    u_bus_master.stop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic k1, k2, k3;
    u_bus_master.start();
    u_bus_master.send_byte({dev, 1'b0}, k1);
    u_bus_master.send_byte(a, k2);
    u_bus_master.send_byte(d, k3);
    u_bus_master.stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic k1, k2;
    u_bus_master.start();
    u_bus_master.send_byte({dev, 1'b0}, k1);
    u_bus_master.send_byte(a, k2);
    u_bus_master.start();
    u_bus_master.send_byte({dev, 1'b1}, k1);
    u_bus_master.read_byte(d);
    u_bus_master.stop();
  endtask
  task automatic chk_out;
    chk({hiz, w2, w1, w0}, {exp_r[2][7], exp_r[1][7], exp_r[0][7],
        exp_r[2][6:0], exp_r[1][6:0], exp_r[0][6:0]});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    chk_out();
    probe({4'ha, sel, 1'b0}, ak);
    chk(ak, 1'b0);
    wait_level(1'b0);
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'hf8 + i[7:0], rd);
      chk(rd, 8'h7f);
    end
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][16:9], rows[i][8:1], ak);
      chk(ak, rows[i][0]);
      if (rows[i][0]) begin
        exp_r[rows[i][10:9]] = rows[i][8:1];
        wait_level(1'b1);
        wait_level(1'b0);
      end
      chk_out();
      rd_reg(rows[i][16:9], rd);
      chk(rd, rows[i][0] ? rows[i][8:1] : 8'h00);
    end
    probe({4'hb, sel, 1'b0}, ak);
    chk(ak, 1'b0);
    probe({4'ha, sel ^ 3'h4, 1'b0}, ak);
    chk(ak, 1'b0);
    sel = 3'h2;
    wr(8'hfa, 8'h80, ak);
    chk(ak, 1'b1);
    probe({4'ha, sel, 1'b0}, ak2);
    chk(ak2, 1'b0);
    wait_level(1'b0);
    exp_r[2] = 8'h80;
    chk_out();
    // Single select pin device: 101000 plus its pin, then read/write.
    one_pin = 1'b1;
    wr(8'hf9, 8'h33, ak);
    chk(ak, 1'b1);
    wait_level(1'b1);
    wait_level(1'b0);
    chk({hiz1, v2, v1, v0}, {3'h0, 7'h7f, 7'h33, 7'h7f});
    chk_out();
    rd_reg(8'hf9, rd);
    chk(rd, 8'h33);
    sel1 = 1'b1;
    probe({6'h28, 1'b0, 1'b0}, ak);
    chk(ak, 1'b0);
    probe({6'h28, 1'b1, 1'b0}, ak);
    chk(ak, 1'b1);
    results();
  end
endmodule // testbench
`default_nettype wire
